// file: src/video_deser_pkg.sv
// Constants, register map and carrier types of the deserializer control bank.
// Assumes one system clock domain; host port and port pins arrive asynchronously.
// Contract
// RL1: New-sync flag sets, holds a line, EAV clears.
// RL2: EAV and SAV bits follow received TRS.
// RL3: Lock status readable, default on port bit 4.
// RL4: Framing enable may come from a port pin.
// RL5: Pattern filter enable drives colour-bar transition coding.
// RL6: De-dither enable switches descrambler output de-dither.
// RL7: Vertical de-dither enable; both de-dither enables reset cleared.
// RL8: External word clock: detector on, pin directions change.
// RL9: Sync-detect enable gates TRS detection.
// RL10: LSB clip forces TRS word low bits 00b.
// RL11: NRZI enable turns on NRZI to NRZ.
// RL12: Descramble enable turns on descrambling.
// RL13: Descrambler control resets 36h; host restores it.
// RL14: Reference gate active low, enabled at reset.
// RL15: Internal oscillator amplifier enable resets to zero.
// RL16: Eight pin select registers 0Fh through 16h.
// RL17: Select bit 5: one input, zero output.
// RL18: Low five bits pick bit; directions must match.
// RL19: Host writes address then data on port clock.
// RL20: Codes 01h-04h map errors, 07h FIFO 90%.
// RL21: Port bit 5 defaults to CRC error code.
// RL22: Codes 05h and 06h map nothing.
// RL23: Output pins show status; input pins drive controls.
package video_deser_pkg;

  // ==========================================================================
  // Register map
  localparam logic [9:0] ADDR_VIDEO_INFO = 10'h00E;
  localparam logic [9:0] ADDR_PIN_FIRST  = 10'h00F;
  localparam logic [9:0] ADDR_PIN_LAST   = 10'h016;
  localparam logic [9:0] ADDR_DESCR      = 10'h055;
  localparam logic [9:0] ADDR_REFCLK     = 10'h067;

  // ==========================================================================
  // Field positions
  localparam int VI_NEWSYNC  = 0;
  localparam int VI_EAV      = 1;
  localparam int VI_SAV      = 2;
  localparam int VI_LOCK     = 3;
  localparam int VI_PATFILT  = 4;
  localparam int VI_DEDITH   = 5;
  localparam int VI_VDEDITH  = 6;
  localparam int VI_FRAMING  = 7;
  localparam logic [7:0] VI_CTRL_MASK = 8'hF0;
  localparam int DC_EXTWCLK  = 0;
  localparam int DC_SYNCDET  = 1;
  localparam int DC_LSBCLIP  = 2;
  localparam int DC_NRZI     = 4;
  localparam int DC_DESCR    = 5;
  localparam int RC_GATE_N   = 0;
  localparam int RC_INTOSC   = 1;
  localparam int SEL_DIR_BIT = 5;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]      VIDEO_INFO_RST = 8'h00;
  localparam logic [7:0]      DESCR_RST      = 8'h36;
  localparam logic [7:0]      REFCLK_RST     = 8'h00;
  localparam logic [7:0][7:0] PIN_SEL_RST    =
    {8'h0E, 8'h1B, 8'h04, 8'h1C, 8'h19, 8'h14, 8'h13, 8'h12};

  // ==========================================================================
  // Select codes (low five bits)
  localparam logic [4:0]  SEL_SAV      = 5'h0D;
  localparam logic [4:0]  SEL_EAV      = 5'h0E;
  localparam logic [4:0]  SEL_NEWSYNC  = 5'h0F;
  localparam logic [4:0]  SEL_LOCK     = 5'h1C;
  localparam logic [4:0]  IN_PATFILT   = 5'h0C;
  localparam logic [4:0]  IN_DEDITH    = 5'h0D;
  localparam logic [4:0]  IN_FRAMING   = 5'h0E;
  localparam logic [31:0] OUT_VALID    = 32'hFFFF_E39E;
  localparam logic [31:0] IN_VALID     = 32'h0000_F1FF;

  // ==========================================================================
  // Timing
  localparam int          HOLD_W       = 16;

  typedef enum logic {PH_ADDR = 1'b0, PH_DATA = 1'b1} phase_t;

  typedef struct packed {
    logic newTrs;
    logic eav;
    logic sav;
    logic lock;
  } video_events_t;

  typedef struct packed {
    logic framingOn;
    logic patternFilterOn;
    logic deditherOn;
    logic vblankDeditherOn;
    logic deditherActive;
    logic extWordClockOn;
    logic videoWordClockIsInput;
    logic biasOrPfdOutput;
    logic syncDetectOn;
    logic trsLowBitsClearOn;
    logic nrziOn;
    logic descrambleOn;
    logic refClockGate_n;
    logic internalOscAmpOn;
  } ctrl_t;

  typedef struct packed {
    logic                  clkMeta;
    logic                  clkSync;
    logic                  clkLast;
    logic                  selMeta;
    logic                  selSync;
    logic                  rwMeta;
    logic                  rwSync;
    logic [9:0]            adMeta;
    logic [9:0]            adSync;
    logic [7:0]            pinMeta;
    logic [7:0]            pinSync;
    phase_t                phase;
    logic [9:0]            addr;
    logic [7:0]            videoInfo;
    logic [7:0]            descr;
    logic [7:0]            refClk;
    logic [7:0][7:0]       pinSel;
    logic                  newSync;
    logic                  eav;
    logic                  sav;
    logic                  lock;
    logic [HOLD_W-1:0]     newSyncHold;
    logic [9:0]            wordOut;
    logic [9:0]            adOut;
    logic                  adOe_n;
    logic [7:0]            pinOut;
    logic [7:0]            pinOe_n;
    logic [31:0]           pinCtrlMask;
    logic [31:0]           pinCtrlVal;
    ctrl_t                 ctrl;
  } state_t;

endpackage

// file: src/video_deser_control_and_port_map.sv
// Control and status bank of the deserializer with the multi-function port map.
// Assumes the video path delivers event pulses on sys_clk; the host port and
// port pins are asynchronous and pass through two flip-flops first.
`timescale 1ns/1ps

module video_deser_control_and_port_map
  import video_deser_pkg::*;
#(
  parameter int LINE_HOLD_CYCLES = 1716
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Ancillary/control port
  input  wire logic          ancClk,
  input  wire logic          ancOrControlSelect,
  input  wire logic          readWrite,
  input  wire logic [9:0]    adIn,
  output logic [9:0]         adOut,
  output logic               adOe_n,
  // Multi-function port
  input  wire logic [7:0]    pinIn,
  output logic [7:0]         pinOut,
  output logic [7:0]         pinOe_n,
  // Video path status
  input  wire video_events_t videoEvents,
  input  wire logic [31:0]   extStatus,
  input  wire logic          inVblank,
  input  wire logic [9:0]    wordIn,
  input  wire logic          wordIsTrs,
  // Video path control
  output logic [9:0]         wordOut,
  output ctrl_t              ctrl,
  output logic [31:0]        pinCtrlMask,
  output logic [31:0]        pinCtrlVal
);

  initial begin
    if (LINE_HOLD_CYCLES < 1 || LINE_HOLD_CYCLES >= (1 << HOLD_W)) begin
      $error("LINE_HOLD_CYCLES out of range");
    end
  end

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(LINE_HOLD_CYCLES);

  state_t st;
  state_t next_st;

  // ==========================================================================
  // Port map per pin
  logic [31:0]      statVec;
  logic [7:0]       pinDrive;
  logic [7:0][31:0] pinMask;

  always_comb begin
    statVec          = extStatus;
    statVec[SEL_SAV]  = st.sav;
    statVec[SEL_EAV]  = st.eav;
    statVec[SEL_NEWSYNC] = st.newSync;
    statVec[SEL_LOCK] = st.lock;
    statVec          = statVec & OUT_VALID; // RL20 RL22
  end

  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_pin
      logic [4:0] code;
      logic       isIn;
      assign code = st.pinSel[p][4:0]; // RL18
      assign isIn = st.pinSel[p][SEL_DIR_BIT]; // RL17
      assign pinDrive[p] = ~isIn & statVec[code]; // RL23 RL18
      assign pinMask[p] = isIn ? ((32'h0000_0001 << code) & IN_VALID) : 32'h0000_0000;

      chk_pin_dir: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL17
        ##1 pinOe_n[p] == $past(st.pinSel[p][SEL_DIR_BIT]))
        else $error("pin direction does not follow select bit 5");
    end
  endgenerate

  logic [31:0] ovrMask;
  logic [31:0] ovrVal;

  always_comb begin
    ovrMask = 32'h0000_0000;
    ovrVal  = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      ovrMask = ovrMask | pinMask[i];
      ovrVal  = ovrVal | (pinMask[i] & {32{st.pinSync[i]}});
    end
  end

  // ==========================================================================
  // Register read and host port
  logic portEdge;
  logic hostWrite;
  logic [2:0] pinIdx;

  assign portEdge  = st.clkSync & ~st.clkLast & ~st.selSync;
  assign hostWrite = portEdge & (st.phase == PH_DATA) & ~st.rwSync;
  assign pinIdx    = 3'(st.addr - ADDR_PIN_FIRST);

  function automatic logic [7:0] readReg(input state_t s, input logic [9:0] a);
    logic [7:0] v;
    logic [2:0] idx;
    v   = 8'h00;
    idx = 3'(a - ADDR_PIN_FIRST);
    if (a == ADDR_VIDEO_INFO) begin
      v = s.videoInfo & VI_CTRL_MASK;
      v[VI_NEWSYNC] = s.newSync;
      v[VI_EAV]  = s.eav;
      v[VI_SAV]  = s.sav;
      v[VI_LOCK] = s.lock; // RL3
    end else if (a >= ADDR_PIN_FIRST && a <= ADDR_PIN_LAST) begin
      v = s.pinSel[idx];
    end else if (a == ADDR_DESCR) begin
      v = s.descr;
    end else if (a == ADDR_REFCLK) begin
      v = s.refClk;
    end
    return v;
  endfunction

  // ==========================================================================
  // Next state
  logic syncDet;
  logic effFraming;
  logic effPatFilt;
  logic effDedith;

  assign syncDet    = st.descr[DC_SYNCDET];
  assign effFraming = ovrMask[IN_FRAMING] ? ovrVal[IN_FRAMING] : st.videoInfo[VI_FRAMING];
  assign effPatFilt = ovrMask[IN_PATFILT] ? ovrVal[IN_PATFILT] : st.videoInfo[VI_PATFILT];
  assign effDedith  = ovrMask[IN_DEDITH] ? ovrVal[IN_DEDITH] : st.videoInfo[VI_DEDITH];

  always_comb begin
    next_st = st;
    next_st.clkMeta = ancClk;
    next_st.clkSync = st.clkMeta;
    next_st.clkLast = st.clkSync;
    next_st.selMeta = ancOrControlSelect;
    next_st.selSync = st.selMeta;
    next_st.rwMeta  = readWrite;
    next_st.rwSync  = st.rwMeta;
    next_st.adMeta  = adIn;
    next_st.adSync  = st.adMeta;
    next_st.pinMeta = pinIn;
    next_st.pinSync = st.pinMeta;

    if (st.selSync) begin
      next_st.phase  = PH_ADDR;
      next_st.adOe_n = 1'b1;
    end else if (portEdge) begin
      if (st.phase == PH_ADDR) begin
        next_st.addr  = st.adSync; // RL19
        next_st.phase = PH_DATA;
        if (st.rwSync) begin
          next_st.adOut  = {2'b00, readReg(st, st.adSync)};
          next_st.adOe_n = 1'b0;
        end
      end else begin
        next_st.phase = PH_ADDR;
      end
    end

    if (hostWrite) begin
      if (st.addr == ADDR_VIDEO_INFO) begin
        next_st.videoInfo = st.adSync[7:0] & VI_CTRL_MASK;
      end else if (st.addr >= ADDR_PIN_FIRST && st.addr <= ADDR_PIN_LAST) begin
        next_st.pinSel[pinIdx] = st.adSync[7:0]; // RL16
      end else if (st.addr == ADDR_DESCR) begin
        next_st.descr = st.adSync[7:0]; // RL13
      end else if (st.addr == ADDR_REFCLK) begin
        next_st.refClk = st.adSync[7:0];
      end
    end

    // New-sync flag holds for a line; an early EAV cannot clear it.
    if (st.newSyncHold != '0) begin
      next_st.newSyncHold = st.newSyncHold - 1'b1;
    end
    if (videoEvents.newTrs & syncDet) begin // RL9
      next_st.newSync     = 1'b1; // RL1
      next_st.newSyncHold = HOLD_LOAD;
    end else if (videoEvents.eav & syncDet & (st.newSyncHold == '0)) begin
      next_st.newSync = 1'b0; // RL1
    end
    if (videoEvents.eav & syncDet) begin
      next_st.eav = 1'b1; // RL2
      next_st.sav = 1'b0;
    end else if (videoEvents.sav & syncDet) begin
      next_st.sav = 1'b1; // RL2
      next_st.eav = 1'b0;
    end
    next_st.lock = videoEvents.lock; // RL3

    if (st.descr[DC_LSBCLIP] & wordIsTrs) begin
      next_st.wordOut = {wordIn[9:2], 2'b00}; // RL10
    end else begin
      next_st.wordOut = wordIn;
    end

    next_st.pinOut      = pinDrive; // RL23
    for (int i = 0; i < 8; i++) begin
      next_st.pinOe_n[i] = st.pinSel[i][SEL_DIR_BIT]; // RL17
    end
    next_st.pinCtrlMask = ovrMask; // RL23
    next_st.pinCtrlVal  = ovrVal;

    next_st.ctrl.framingOn             = effFraming; // RL4
    next_st.ctrl.patternFilterOn       = effPatFilt; // RL5
    next_st.ctrl.deditherOn            = effDedith; // RL6
    next_st.ctrl.vblankDeditherOn      = st.videoInfo[VI_VDEDITH]; // RL7
    next_st.ctrl.deditherActive        = effDedith & (~inVblank | st.videoInfo[VI_VDEDITH]);
    next_st.ctrl.extWordClockOn        = st.descr[DC_EXTWCLK]; // RL8
    next_st.ctrl.videoWordClockIsInput = st.descr[DC_EXTWCLK]; // RL8
    next_st.ctrl.biasOrPfdOutput       = st.descr[DC_EXTWCLK]; // RL8
    next_st.ctrl.syncDetectOn          = syncDet; // RL9
    next_st.ctrl.trsLowBitsClearOn     = st.descr[DC_LSBCLIP]; // RL10
    next_st.ctrl.nrziOn                = st.descr[DC_NRZI]; // RL11
    next_st.ctrl.descrambleOn          = st.descr[DC_DESCR]; // RL12
    next_st.ctrl.refClockGate_n        = st.refClk[RC_GATE_N]; // RL14
    next_st.ctrl.internalOscAmpOn      = st.refClk[RC_INTOSC]; // RL15
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st           <= '0;
      st.adOe_n    <= 1'b1;
      st.pinOe_n   <= 8'h00;
      st.videoInfo <= VIDEO_INFO_RST; // RL7
      st.descr     <= DESCR_RST; // RL13
      st.refClk    <= REFCLK_RST; // RL14 RL15
      st.pinSel    <= PIN_SEL_RST; // RL3 RL21
      st.selMeta   <= 1'b1;
      st.selSync   <= 1'b1;
      st.ctrl.syncDetectOn      <= DESCR_RST[DC_SYNCDET];
      st.ctrl.trsLowBitsClearOn <= DESCR_RST[DC_LSBCLIP];
      st.ctrl.nrziOn            <= DESCR_RST[DC_NRZI];
      st.ctrl.descrambleOn      <= DESCR_RST[DC_DESCR];
    end else begin
      st <= next_st;
    end
  end

  assign adOut       = st.adOut;
  assign adOe_n      = st.adOe_n;
  assign pinOut      = st.pinOut;
  assign pinOe_n     = st.pinOe_n;
  assign wordOut     = st.wordOut;
  assign ctrl        = st.ctrl;
  assign pinCtrlMask = st.pinCtrlMask;
  assign pinCtrlVal  = st.pinCtrlVal;

  // ==========================================================================
  // Checks
  logic cfgWritten;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgWritten <= 1'b0;
    end else if (hostWrite) begin
      cfgWritten <= 1'b1;
    end
  end

  sequence s_newTrs;
    videoEvents.newTrs && syncDet;
  endsequence

  sequence s_pinWrite;
    hostWrite && st.addr >= ADDR_PIN_FIRST && st.addr <= ADDR_PIN_LAST;
  endsequence

  chk_newsync_set: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL1
    s_newTrs |=> st.newSync && st.newSyncHold == HOLD_LOAD)
    else $error("new-sync flag not set with full hold");

  chk_newsync_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL1
    st.newSync && st.newSyncHold != '0 |=> st.newSync)
    else $error("new-sync flag dropped before a line elapsed");

  chk_eav_track: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL2
    videoEvents.eav && syncDet |=> st.eav && !st.sav)
    else $error("EAV status did not follow EAV arrival");

  chk_sync_gate: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL9
    !syncDet && !st.newSync && !videoEvents.eav |=> !st.newSync)
    else $error("new-sync flag set while detection disabled");

  chk_lock_pin: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL3
    st.pinSel[4] == {3'b000, SEL_LOCK} && $past(st.pinSel[4]) == {3'b000, SEL_LOCK}
      && $past(st.pinSel[4], 2) == {3'b000, SEL_LOCK}
      |-> pinOut[4] == $past(videoEvents.lock, 2))
    else $error("lock status not on its mapped pin");

  chk_clip_trs: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL10
    st.descr[DC_LSBCLIP] && wordIsTrs |=> wordOut[1:0] == 2'b00
      && wordOut[9:2] == $past(wordIn[9:2]))
    else $error("TRS word low bits not cleared");

  chk_descr_default: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL13
    !cfgWritten |-> st.descr == DESCR_RST && ctrl.descrambleOn && ctrl.nrziOn)
    else $error("descrambler control lost its reset value");

  chk_refclk_default: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL14
    !cfgWritten |-> !ctrl.refClockGate_n && !ctrl.internalOscAmpOn) // RL15
    else $error("reference clock controls not at reset state");

  chk_pin_write: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL16
    s_pinWrite |=> st.pinSel[$past(pinIdx)] == $past(st.adSync[7:0]))
    else $error("pin select register not written");

  chk_reserved_code: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL22
    st.pinSel[4] == 8'h05 && st.pinSel[5] == 8'h06 |=> !pinOut[4] && !pinOut[5])
    else $error("reserved select code drives a pin");

  chk_ext_wclk: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL8
    st.descr[DC_EXTWCLK] |=> ctrl.videoWordClockIsInput && ctrl.biasOrPfdOutput)
    else $error("external word clock did not switch pins");

  chk_framing_pin: assert property (@(posedge sys_clk) disable iff (!arst_n) // RL4
    ovrMask[IN_FRAMING] |=> ctrl.framingOn == $past(ovrVal[IN_FRAMING]))
    else $error("framing enable not taken from its input pin");

endmodule // video_deser_control_and_port_map

// file: testbench/host_port_model.sv
// Host controller model for the ancillary/control port of the deserializer bank.
// Assumes xfer is called on a sys_clk rising edge; the port clock idles low.
`timescale 1ns/1ps

module host_port_model (
  // Clock
  input  wire logic       sys_clk,
  // Port toward the device
  input  wire logic [9:0] adOut,
  input  wire logic       adOe_n,
  output logic            ancClk,
  output logic            ancOrControlSelect,
  output logic            readWrite,
  output logic [9:0]      hostAd
);
  initial begin
    ancClk             = 1'b0;
    ancOrControlSelect = 1'b1;
    readWrite          = 1'b1;
    hostAd             = 10'h155;
  end

  task automatic half(input logic c, input logic [9:0] d);
    ancClk <= c;
    hostAd <= d;
    repeat (4) @(posedge sys_clk);
  endtask

  // =========================================================================
  // Transfer
  // Address then data, each set up half a port-clock period before its rise.
  task automatic xfer(input logic [9:0] a, input logic [9:0] d, input logic rd,
                      output logic [9:0] q, output logic ok);
    ancOrControlSelect <= 1'b0;
    readWrite          <= rd;
    half(1'b0, a);
    half(1'b1, a);
    half(1'b0, d);
    half(1'b1, d);
    q  = adOut;
    ok = (adOe_n === 1'b0);
    half(1'b0, ~d);
    ancOrControlSelect <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // host_port_model

// file: testbench/test_video_deser_control_and_port_map.sv
// Self-checking bench for the deserializer control bank and its port map.
// Assumes host_port_model drives the host port; video events come from here.
`timescale 1ns/1ps

module test_video_deser_control_and_port_map;
  import video_deser_pkg::*;
  localparam int HOLD = 8;
  logic            sys_clk;
  logic            arst_n;
  logic            ancClk;
  logic            ancOrControlSelect;
  logic            readWrite;
  logic [9:0]      hostAd;
  logic [9:0]      adOut;
  logic            adOe_n;
  logic [7:0]      pinIn;
  logic [7:0]      pinOut;
  logic [7:0]      pinOe_n;
  video_events_t   ev;
  logic [31:0]     extStatus;
  logic            inVblank;
  logic [9:0]      wordIn;
  logic            wordIsTrs;
  logic [9:0]      wordOut;
  ctrl_t           ctrl;
  logic [31:0]     pinCtrlMask;
  logic [31:0]     pinCtrlVal;
  wire logic [9:0] adBus = adOe_n ? hostAd : adOut;
  wire logic [2:0] ovrCtrl = {ctrl.patternFilterOn, ctrl.deditherOn, ctrl.framingOn};
  int              seed = 32'h95df;
  int              fail_count = 0;
  int              tests_run = 0;

  host_port_model host (.sys_clk(sys_clk), .adOut(adOut), .adOe_n(adOe_n), .ancClk(ancClk),
    .ancOrControlSelect(ancOrControlSelect), .readWrite(readWrite), .hostAd(hostAd));

  video_deser_control_and_port_map #(.LINE_HOLD_CYCLES(HOLD)) dut (.sys_clk(sys_clk),
    .arst_n(arst_n), .ancClk(ancClk), .ancOrControlSelect(ancOrControlSelect),
    .readWrite(readWrite), .adIn(adBus), .adOut(adOut), .adOe_n(adOe_n), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe_n(pinOe_n), .videoEvents(ev), .extStatus(extStatus),
    .inVblank(inVblank), .wordIn(wordIn), .wordIsTrs(wordIsTrs), .wordOut(wordOut),
    .ctrl(ctrl), .pinCtrlMask(pinCtrlMask), .pinCtrlVal(pinCtrlVal));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // =========================================================================
  // Expectations and checks
  // Reserved codes drive low; the internal video status slots are idle then.
  function automatic logic exp_pin(input logic [4:0] c, input logic [31:0] s);
    return (c inside {5'h00, 5'h05, 5'h06, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h1C})
           ? 1'b0 : s[c];
  endfunction

  function automatic logic [9:0] exp_word(input logic [9:0] v, input logic t, input logic c);
    return (t && c) ? {v[9:2], 2'b00} : v;
  endfunction

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [9:0] q;
    logic       ok;
    host.xfer(a, {2'b00, d}, 1'b0, q, ok);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [9:0] q;
    logic       ok;
    host.xfer(a, ~a, 1'b1, q, ok);
    chk_bit(ok, 1'b1, "read drive");
    chk_val(q, {2'b00, e}, "read data");
  endtask

  task automatic pulse(input logic [2:0] m);
    ev[3:1] <= m;
    w(1);
    ev[3:1] <= 3'b000;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    w(20000);
    fail_count++;
    $display("unexpected at %0t: run timed out", $time);
    results();
  end

  // =========================================================================
  // Main sequence
  initial begin : main
    logic [7:0] c;
    logic [2:0] p;
    logic [9:0] vin;
    logic       t;
    int         k;
    logic [7:0] dv [7];
    dv = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h36};
    arst_n    = 1'b0;
    pinIn     = 8'h00;
    ev        = '0;
    extStatus = 32'h0;
    inVblank  = 1'b0;
    wordIn    = 10'h000;
    wordIsTrs = 1'b0;
    w(20);
    arst_n <= 1'b1;
    w(4);
    chk_val({2'b00, pinOe_n}, 10'h000, "reset dir");
    chk_bit(ctrl.refClockGate_n, 1'b0, "reset gate");
    chk_bit(ctrl.deditherOn, 1'b0, "reset dedither");
    rd(ADDR_DESCR, 8'h36);
    rd(ADDR_REFCLK, 8'h00);
    rd(ADDR_VIDEO_INFO, 8'h00);
    rd(ADDR_PIN_FIRST + 10'h4, 8'h1C);
    rd(ADDR_PIN_FIRST + 10'h5, 8'h04);
    for (k = 0; k < 8; k++) rd(ADDR_PIN_FIRST + 10'(k), PIN_SEL_RST[k]);
    wr(10'h0EE, 8'hA5);
    rd(10'h0EE, 8'h00);
    $display("test reset done");
    for (k = 0; k < 16; k++) begin
      c = (k < 7) ? 8'(k + 1) : 8'($random(seed) & 8'h1F);
      p = 3'(k);
      extStatus <= $random(seed);
      wr(ADDR_PIN_FIRST + 10'(p), c);
      rd(ADDR_PIN_FIRST + 10'(p), c);
      chk_bit(pinOe_n[p], 1'b0, "out dir");
      chk_bit(pinOut[p], exp_pin(c[4:0], extStatus), "mapped");
      extStatus <= ~extStatus;
      w(4);
      chk_bit(pinOut[p], exp_pin(c[4:0], extStatus), "follows");
    end
    $display("test output map done");
    for (k = 0; k < 3; k++) begin
      wr(ADDR_PIN_FIRST + 10'h1, 8'h2C + 8'(k));
      pinIn[1] <= 1'b1;
      w(6);
      chk_bit(pinOe_n[1], 1'b1, "in dir");
      chk_val({7'h00, ovrCtrl}, 10'(4 >> k), "pin hi");
      pinIn[1] <= 1'b0;
      w(6);
      chk_val({7'h00, ovrCtrl}, 10'h0, "pin lo");
    end
    k = $random(seed) & 7;
    wr(ADDR_PIN_FIRST + 10'h2, 8'h20 + 8'(k));
    pinIn[2] <= 1'b1;
    w(6);
    chk_bit(pinCtrlMask[k], 1'b1, "export mask");
    chk_bit(pinCtrlVal[k], 1'b1, "export value");
    $display("test input map done");
    for (k = 0; k < 7; k++) begin
      c = dv[k];
      wr(ADDR_DESCR, c);
      rd(ADDR_DESCR, c);
      chk_bit(ctrl.syncDetectOn, c[DC_SYNCDET], "sync det");
      chk_bit(ctrl.trsLowBitsClearOn, c[DC_LSBCLIP], "clip on");
      chk_bit(ctrl.nrziOn, c[DC_NRZI], "nrzi");
      chk_bit(ctrl.descrambleOn, c[DC_DESCR], "descramble");
      chk_bit(ctrl.videoWordClockIsInput, c[DC_EXTWCLK], "wclk in");
      chk_bit(ctrl.biasOrPfdOutput, c[DC_EXTWCLK], "pfd out");
      chk_bit(ctrl.extWordClockOn, c[DC_EXTWCLK], "pfd on");
      vin = 10'($random(seed)) | 10'h001;
      t = 1'($random(seed)) | k[1];
      wordIn <= vin;
      wordIsTrs <= t;
      w(1);
      #1 chk_val(wordOut, exp_word(vin, t, c[DC_LSBCLIP]), "clip");
      w(1);
    end
    $display("test descrambler done");
    wr(ADDR_VIDEO_INFO, 8'h7F);
    inVblank <= 1'b1;
    w(3);
    chk_bit(ctrl.deditherActive, 1'b1, "v dedither");
    chk_bit(ctrl.patternFilterOn, 1'b1, "filter");
    chk_bit(ctrl.vblankDeditherOn, 1'b1, "v enable");
    rd(ADDR_VIDEO_INFO, VI_CTRL_MASK & 8'h7F);
    wr(ADDR_VIDEO_INFO, 8'(1 << VI_DEDITH));
    chk_bit(ctrl.deditherActive, 1'b0, "vblank off");
    chk_bit(ctrl.vblankDeditherOn, 1'b0, "v disable");
    inVblank <= 1'b0;
    w(3);
    chk_bit(ctrl.deditherActive, 1'b1, "dedither");
    chk_bit(ctrl.patternFilterOn, 1'b0, "filter off");
    wr(ADDR_PIN_FIRST + 10'h6, {3'b000, SEL_NEWSYNC});
    wr(ADDR_PIN_FIRST + 10'h7, {3'b000, SEL_EAV});
    wr(ADDR_PIN_FIRST + 10'h5, {3'b000, SEL_SAV});
    wr(ADDR_PIN_FIRST + 10'h4, {3'b000, SEL_LOCK});
    pulse(3'b100);
    w(3);
    chk_bit(pinOut[6], 1'b1, "new sync");
    pulse(3'b010);
    w(3);
    chk_bit(pinOut[6], 1'b1, "held");
    chk_bit(pinOut[7], 1'b1, "eav");
    w(HOLD);
    pulse(3'b010);
    w(3);
    chk_bit(pinOut[6], 1'b0, "eav clears");
    ev.lock <= 1'b1;
    pulse(3'b001);
    w(4);
    chk_bit(pinOut[7], 1'b0, "eav off");
    chk_bit(pinOut[5], 1'b1, "sav");
    chk_bit(pinOut[4], 1'b1, "lock pin");
    rd(ADDR_VIDEO_INFO, 8'(1 << VI_SAV) | 8'(1 << VI_LOCK) | 8'(1 << VI_DEDITH));
    wr(ADDR_DESCR, 8'h36 & ~8'(1 << DC_SYNCDET));
    pulse(3'b100);
    w(3);
    chk_bit(pinOut[6], 1'b0, "sync gated");
    wr(ADDR_DESCR, 8'h36);
    $display("test video status done");
    wr(ADDR_REFCLK, 8'(1 << RC_INTOSC));
    chk_bit(ctrl.internalOscAmpOn, 1'b1, "osc amp");
    chk_bit(ctrl.refClockGate_n, 1'b0, "ref on");
    wr(ADDR_REFCLK, 8'(1 << RC_GATE_N));
    chk_bit(ctrl.refClockGate_n, 1'b1, "ref gated");
    $display("test ref clock done");
    results();
  end
endmodule // test_video_deser_control_and_port_map
